// file: bench/clock_path_control_tb.sv
// Self-checking bench for the clock path control register file and decode.
`timescale 1ns/100ps
`include "clock_path_defs.vh"
module clock_path_control_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic loop_bypass_pin = 1'b0;
  wire [7:0] reg_rdata;
  wire reg_rvalid, divider_reset, divider_release, skew_clear, ref_out_oe, ref_out_off;
  wire second_pole_select, lock_count_accuracy, lock_override_manual;
  wire manual_oscillator_pick, fractional_feedback_off;
  wire [31:0] fine_phase_applied;
  wire [47:0] pair_source;
  wire [9:0] divider_power_down, path_off;
  wire [11:0] pair_buffer_off;
  wire [1:0] prescale_mode, loop_series_resistor, loop_parallel_cap;
  wire [2:0] pump_current_code;
  wire [4:0] osc_manual_lock_code;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int pulses = 0;
  logic [7:0] rd_val;
  logic [39:0] rows [0:14];

  clock_path_control clock_path_control_i (.clock, .nrst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .reg_rvalid, .loop_bypass_pin, .divider_reset, .divider_release,
    .skew_clear, .fine_phase_applied, .pair_source, .divider_power_down, .path_off,
    .pair_buffer_off, .ref_out_oe, .ref_out_off, .prescale_mode, .pump_current_code,
    .loop_series_resistor, .loop_parallel_cap, .second_pole_select, .lock_count_accuracy,
    .lock_override_manual, .manual_oscillator_pick, .osc_manual_lock_code,
    .fractional_feedback_off);

  always #20 clock = ~clock;

  // The ceiling is several times the expected run, so only a hang reaches it.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (divider_release === 1'b1) pulses <= pulses + 1;
    if (cycles == 3000) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    chk(reg_rvalid, 1'b1);
    d = reg_rdata;
  endtask

  task automatic stop_test;
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence.
  // ----------------------------------------------------------------
  initial begin
    // Row: address, reset value, write value, read-back value.
    rows = '{40'h0087_44_12_12, 40'h008E_00_FF_03, 40'h008F_00_FF_FE, 40'h0090_00_FF_01,
      40'h0091_00_FF_FF, 40'h009A_8B_FF_FF, 40'h009B_02_FF_03, 40'h009C_2B_FF_3F,
      40'h009D_00_15_15, 40'h009E_03_FF_17, 40'h009F_00_FF_00, 40'h00A0_00_FF_FF,
      40'h00A1_00_FF_13, 40'h00A2_00_FF_02, 40'h0100_00_FF_00};
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    for (int i = 0; i < 15; i++) begin
      rd(rows[i][39:24], rd_val);
      chk(rd_val, rows[i][23:16]);
      wr(rows[i][39:24], rows[i][15:8]);
      rd(rows[i][39:24], rd_val);
      chk(rd_val, rows[i][7:0]);
    end
    chk(pair_source, 48'h8899_6745_AAAA);
    chk(divider_power_down, 10'h2FF);
    chk({path_off, pair_buffer_off}, {10'h3FF, 12'hFFF});
    chk({loop_series_resistor, loop_parallel_cap, second_pole_select, lock_count_accuracy,
      lock_override_manual, manual_oscillator_pick, osc_manual_lock_code},
      {2'h3, 2'h3, 4'hF, 5'h1F});
    chk({ref_out_oe, ref_out_off, fractional_feedback_off}, 3'h7);
    wr(`ADDR_MUX_INT, 8'h00);
    wr(`ADDR_MUX_FRAC, 8'h00);
    wr(`ADDR_VCO1_LOCK, 8'h0B);
    for (int j = 0; j < 8; j++) begin
      wr(`ADDR_PUMP_FILTER, {j[2:0], 5'h15});
      wr(`ADDR_BYP_REF_PRE, {6'h00, j[1:0]});
      repeat (2) @(negedge clock);
      chk({pump_current_code, prescale_mode}, {j[2:0], j[1:0]});
    end
    chk(pair_source, 48'h9988_7654_3210);
    chk({ref_out_oe, manual_oscillator_pick, osc_manual_lock_code}, 7'h15);
    loop_bypass_pin = 1'b1;
    repeat (5) @(negedge clock);
    chk(pair_source[15:0], 16'hAAAA);
    loop_bypass_pin = 1'b0;
    repeat (5) @(negedge clock);
    chk(pair_source[15:0], 16'h3210);
    // A repeated set must not count as a second edge.
    wr(`ADDR_SYNC, 8'h01);
    wr(`ADDR_SYNC, 8'h01);
    repeat (3) @(negedge clock);
    chk({divider_reset, pulses[7:0]}, 9'h100);
    chk(fine_phase_applied, 32'h4444_4444);
    wr(`ADDR_SYNC, 8'h00);
    repeat (3) @(negedge clock);
    chk({divider_reset, pulses[7:0]}, 9'h001);
    chk(fine_phase_applied, 32'h4444_4142);
    wr(`ADDR_SYNC, 8'h00);
    repeat (3) @(negedge clock);
    chk(pulses[7:0], 8'h01);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    chk({fine_phase_applied, pair_source[47:32]}, {32'h4444_4444, 16'h9988});
    chk({pump_current_code, loop_series_resistor, loop_parallel_cap, second_pole_select},
      {3'h4, 2'h1, 2'h1, 1'b1});
    // Pairs 8 to 11 are moved onto divider I before divider J is powered down.
    wr(`ADDR_MUX_INT, 8'h02);
    wr(`ADDR_DIV_J_PWR, 8'h01);
    repeat (2) @(negedge clock);
    chk({pair_source[47:32], divider_power_down[9]}, {16'h8888, 1'b1});
    stop_test();
  end
endmodule

bind clock_path_control clock_path_props #(.DIVIDERS(DIVIDERS), .PAIRS(PAIRS)) props_i (.clock,
  .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid,
  .loop_bypass_pin, .divider_reset, .divider_release, .skew_clear, .fine_phase_applied,
  .pair_source, .divider_power_down, .path_off, .pair_buffer_off);

// file: bench/clock_path_props.sv
// Concurrent checks on the ports of the clock path control.
`timescale 1ns/100ps
`include "clock_path_defs.vh"
module clock_path_props #(
  parameter DIVIDERS = 10,
  parameter PAIRS = 12
) (
  input wire clock,
  input wire nrst,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire loop_bypass_pin,
  input wire divider_reset,
  input wire divider_release,
  input wire skew_clear,
  input wire [31:0] fine_phase_applied,
  input wire [4*PAIRS-1:0] pair_source,
  input wire [DIVIDERS-1:0] divider_power_down,
  input wire [DIVIDERS-1:0] path_off,
  input wire [PAIRS-1:0] pair_buffer_off
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire sync_wr = reg_write && reg_addr == `ADDR_SYNC;
  wire clear_wr = sync_wr && !reg_wdata[0];
  // ----------------------------------------------------------------
  // Synchronisation.
  // ----------------------------------------------------------------
  AST_SYNC_HOLD: assert property (sync_wr && reg_wdata[0] |-> ##[1:2] divider_reset)
    else $error("divider reset not raised after sync set");
  AST_SYNC_KEEP: assert property ($fell(divider_reset) |-> $past(clear_wr) || $past(clear_wr, 2))
    else $error("divider reset dropped without a sync clear");
  AST_SYNC_FREE: assert property (clear_wr && divider_reset |->
    ##[1:2] (divider_release && skew_clear && !divider_reset))
    else $error("sync clear did not release the dividers");
  AST_PULSE_ONE: assert property (divider_release |=> !divider_release)
    else $error("release pulse longer than one cycle");
  AST_PULSE_PAIR: assert property (divider_release == skew_clear)
    else $error("skew clear not aligned with release");
  AST_EDGE_ONLY: assert property (divider_release |-> $fell(divider_reset))
    else $error("release without a real sync change");
  AST_FINE_AT_SYNC: assert property ($changed(fine_phase_applied) |-> divider_release)
    else $error("fine phase applied outside a release");
  // ----------------------------------------------------------------
  // Paths, sources and reads.
  // ----------------------------------------------------------------
  AST_BYPASS_PIN: assert property (loop_bypass_pin [*5] |-> pair_source[15:0] == 16'hAAAA)
    else $error("bypass pin did not route reference to pairs 0 to 3");
  AST_PATH_IJ: assert property (pair_buffer_off ==
    {{2{path_off[9]}}, {2{path_off[8]}}, path_off[7:0]})
    else $error("pair buffer power does not follow path power");
  AST_NO_DIVI_PWR: assert property (!divider_power_down[8])
    else $error("divider I power bit set");
  AST_PAIR1_SRC: assert property (pair_source[7:4] == `SRC_B || pair_source[7:4] == `SRC_A
    || pair_source[7:4] == `SRC_REF)
    else $error("pair 1 fed from an illegal source");
  AST_SPARE_READ: assert property (reg_read && reg_addr == `ADDR_PLL_SPARE |=>
    reg_rvalid && reg_rdata == 8'h00)
    else $error("spare register read not zero");
endmodule

// file: core/clock_path_control.v
// Register file and control decode for the clock synthesizer output paths and loop.
//
// Overview of operation
// RULE1: Sync bit rising holds every output divider in reset until it clears.
// RULE2: Sync bit falling releases all dividers together and zeroes skew adjustment.
// RULE3: Pairs 10 and 11 use divider J at select 0, I at 1; default 0.
// RULE4: Pairs 8 and 9 use divider I at select 0, J at 1.
// RULE5: Pair 7 uses H or G, pair 6 uses G or H by select.
// RULE6: Pair 5 uses F or E, pair 4 uses E or F by select.
// RULE7: Pair 3 uses divider D at select 0, divider A at 1.
// RULE8: Pair 2 uses divider C at select 0, divider A at 1.
// RULE9: Pair 1 uses divider B at select 0, divider A at 1.
// RULE10: Software writes zero to reserved bits; their read value is not guaranteed.
// RULE11: Each divider A to J has a power-down bit, 1 powers down. The code has no bit for divider I and holds its position low.
// RULE12: Lock count 0 gives 1 ppm, 1 gives 16 ppm; default 1.
// RULE13: Lock override 0 is automatic lock mode, 1 is manual; default 0.
// RULE14: Manual oscillator pick 0 is VCO2, 1 is VCO1; two 5-bit lock codes.
// RULE15: Bypass bit or pin puts the input reference onto pairs 0 to 3.
// RULE16: Reference output is high-impedance at enable 0, driven at 1.
// RULE17: Pre-scaler code 00 passes, 01 halves, 10 quarters, 11 doubles; default 11.
// RULE18: Path-off bit 1 switches off divider, buffer and mux regulator.
// RULE19: Path I powers off pairs 8 and 9, path J pairs 10 and 11.
// RULE20: Software moves selects away from a function before powering it down.
// RULE21: Charge pump code 000 to 111 gives 110 to 880 uA; default 100.
// RULE22: Series resistor, parallel capacitor and second pole settings drive the filter.
// RULE23: Fine phase values take effect only after the sync bit is toggled.
// RULE24: Sync edges are found by comparing a written bit with the stored one.
`timescale 1ns/100ps
`include "clock_path_defs.vh"

module clock_path_control #(
  parameter DIVIDERS = 10,
  parameter PAIRS = 12
) (
  input wire clock,
  input wire nrst,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  input wire loop_bypass_pin,
  output reg divider_reset,
  output reg divider_release,
  output reg skew_clear,
  output reg [31:0] fine_phase_applied,
  output reg [4*PAIRS-1:0] pair_source,
  output reg [DIVIDERS-1:0] divider_power_down,
  output reg [DIVIDERS-1:0] path_off,
  output reg [PAIRS-1:0] pair_buffer_off,
  output reg ref_out_oe,
  output reg ref_out_off,
  output reg [1:0] prescale_mode,
  output reg [2:0] pump_current_code,
  output reg [1:0] loop_series_resistor,
  output reg [1:0] loop_parallel_cap,
  output reg second_pole_select,
  output reg lock_count_accuracy,
  output reg lock_override_manual,
  output reg manual_oscillator_pick,
  output reg [4:0] osc_manual_lock_code,
  output reg fractional_feedback_off
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [7:0] fine_ca;
  reg [7:0] fine_db;
  reg [7:0] fine_ge;
  reg [7:0] fine_hf;
  reg output_sync_ctrl;
  reg [7:0] mux_int;
  reg [7:0] mux_frac;
  reg [7:0] div_j_pwr;
  reg [7:0] div_ah_pwr;
  reg [7:0] pump_filter;
  reg [7:0] lock_mode;
  reg [7:0] vco1_lock;
  reg [7:0] vco2_lock;
  reg [7:0] byp_ref_pre;
  reg [7:0] path_ah_pwr;
  reg [7:0] ref_path_j;
  reg [7:0] fb_mode;
  reg bypass_meta;
  reg bypass_sync;

  wire sync_wr;
  wire sync_rise;
  wire sync_fall;
  wire bypass_active;

  reg [7:0] next_rdata;
  reg [4*PAIRS-1:0] next_source;
  reg [PAIRS-1:0] next_buffer_off;

  function [3:0] pick;
    input sel;
    input [3:0] src_zero;
    input [3:0] src_one;
    begin
      pick = sel ? src_one : src_zero;
    end
  endfunction

  // Bypass overrides the normal source of pairs 0 to 3 only. [RULE15]
  function [3:0] steer;
    input bypass;
    input [3:0] src;
    begin
      steer = bypass ? `SRC_REF : src;
    end
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign sync_wr = reg_write && (reg_addr == `ADDR_SYNC);
  // Only a real change of the stored bit counts as an edge. [RULE24]
  assign sync_rise = sync_wr && reg_wdata[`BIT_SYNC] && !output_sync_ctrl; // [RULE24]
  assign sync_fall = sync_wr && !reg_wdata[`BIT_SYNC] && output_sync_ctrl; // [RULE24]

  // Reserved bits are masked off on write and read back as zero. [RULE10]
  always @(posedge clock) begin
    if (!nrst) begin
      fine_ca <= `RST_FINE;
      fine_db <= `RST_FINE;
      fine_ge <= `RST_FINE;
      fine_hf <= `RST_FINE;
      output_sync_ctrl <= 1'b0;
      mux_int <= `RST_ZERO;
      mux_frac <= `RST_ZERO;
      div_j_pwr <= `RST_ZERO;
      div_ah_pwr <= `RST_ZERO;
      pump_filter <= `RST_PUMP_FILTER;
      lock_mode <= `RST_LOCK_MODE;
      vco1_lock <= `RST_VCO1_LOCK;
      vco2_lock <= `RST_VCO2_LOCK;
      byp_ref_pre <= `RST_BYP_REF_PRE;
      path_ah_pwr <= `RST_ZERO;
      ref_path_j <= `RST_ZERO;
      fb_mode <= `RST_ZERO;
    end else if (reg_write) begin
      case (reg_addr)
        `ADDR_FINE_CA: fine_ca <= reg_wdata;
        `ADDR_FINE_DB: fine_db <= reg_wdata;
        `ADDR_FINE_GE: fine_ge <= reg_wdata;
        `ADDR_FINE_HF: fine_hf <= reg_wdata;
        `ADDR_SYNC: output_sync_ctrl <= reg_wdata[`BIT_SYNC];
        `ADDR_MUX_INT: mux_int <= reg_wdata & `MASK_MUX_INT;
        `ADDR_MUX_FRAC: mux_frac <= reg_wdata & `MASK_MUX_FRAC;
        `ADDR_DIV_J_PWR: div_j_pwr <= reg_wdata & `MASK_DIV_J_PWR;
        `ADDR_DIV_AH_PWR: div_ah_pwr <= reg_wdata;
        `ADDR_PUMP_FILTER: pump_filter <= reg_wdata;
        `ADDR_LOCK_MODE: lock_mode <= reg_wdata & `MASK_LOCK_MODE;
        `ADDR_VCO1_LOCK: vco1_lock <= reg_wdata & `MASK_VCO1_LOCK;
        `ADDR_VCO2_LOCK: vco2_lock <= reg_wdata & `MASK_VCO2_LOCK;
        `ADDR_BYP_REF_PRE: byp_ref_pre <= reg_wdata & `MASK_BYP_REF_PRE;
        `ADDR_PATH_AH_PWR: path_ah_pwr <= reg_wdata;
        `ADDR_REF_PATH_J: ref_path_j <= reg_wdata & `MASK_REF_PATH_J;
        `ADDR_FB_MODE: fb_mode <= reg_wdata & `MASK_FB_MODE;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @* begin
    case (reg_addr)
      `ADDR_FINE_CA: next_rdata = fine_ca;
      `ADDR_FINE_DB: next_rdata = fine_db;
      `ADDR_FINE_GE: next_rdata = fine_ge;
      `ADDR_FINE_HF: next_rdata = fine_hf;
      `ADDR_SYNC: next_rdata = {7'h00, output_sync_ctrl};
      `ADDR_MUX_INT: next_rdata = mux_int;
      `ADDR_MUX_FRAC: next_rdata = mux_frac;
      `ADDR_DIV_J_PWR: next_rdata = div_j_pwr;
      `ADDR_DIV_AH_PWR: next_rdata = div_ah_pwr;
      `ADDR_PUMP_FILTER: next_rdata = pump_filter;
      `ADDR_LOCK_MODE: next_rdata = lock_mode;
      `ADDR_VCO1_LOCK: next_rdata = vco1_lock;
      `ADDR_VCO2_LOCK: next_rdata = vco2_lock;
      `ADDR_BYP_REF_PRE: next_rdata = byp_ref_pre;
      `ADDR_PATH_AH_PWR: next_rdata = path_ah_pwr;
      `ADDR_REF_PATH_J: next_rdata = ref_path_j;
      `ADDR_FB_MODE: next_rdata = fb_mode;
      default: next_rdata = `RST_ZERO;
    endcase
  end

  always @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= `RST_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      // A read in the same cycle as a write still returns the old contents.
      reg_rvalid <= reg_read;
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bypass pin synchroniser
  // ----------------------------------------------------------------
  // Only the second stage is read; the first may still be settling.
  always @(posedge clock) begin
    if (!nrst) begin
      bypass_meta <= 1'b0;
      bypass_sync <= 1'b0;
    end else begin
      bypass_meta <= loop_bypass_pin;
      bypass_sync <= bypass_meta;
    end
  end

  // The register bit and the pin act alike; either one bypasses. [RULE15]
  assign bypass_active = byp_ref_pre[`BIT_BYPASS] | bypass_sync; // [RULE15]

  // ----------------------------------------------------------------
  // Output pair source selection
  // ----------------------------------------------------------------
  always @* begin
    next_source = {4*PAIRS{1'b0}};
    next_source[3:0] = steer(bypass_active, `SRC_A); // [RULE15]
    next_source[7:4] = steer(bypass_active,
                             pick(mux_frac[`BIT_MUX_1], `SRC_B, `SRC_A)); // [RULE9]
    next_source[11:8] = steer(bypass_active,
                              pick(mux_frac[`BIT_MUX_2], `SRC_C, `SRC_A)); // [RULE8]
    next_source[15:12] = steer(bypass_active,
                               pick(mux_frac[`BIT_MUX_3], `SRC_D, `SRC_A)); // [RULE7]
    next_source[19:16] = pick(mux_frac[`BIT_MUX_4], `SRC_E, `SRC_F); // [RULE6]
    next_source[23:20] = pick(mux_frac[`BIT_MUX_5], `SRC_F, `SRC_E); // [RULE6]
    next_source[27:24] = pick(mux_frac[`BIT_MUX_6], `SRC_G, `SRC_H); // [RULE5]
    next_source[31:28] = pick(mux_frac[`BIT_MUX_7], `SRC_H, `SRC_G); // [RULE5]
    next_source[35:32] = pick(mux_int[`BIT_MUX_8_9], `SRC_I, `SRC_J); // [RULE4]
    next_source[39:36] = pick(mux_int[`BIT_MUX_8_9], `SRC_I, `SRC_J); // [RULE4]
    next_source[43:40] = pick(mux_int[`BIT_MUX_10_11], `SRC_J, `SRC_I); // [RULE3]
    next_source[47:44] = pick(mux_int[`BIT_MUX_10_11], `SRC_J, `SRC_I); // [RULE3]
  end

  // Each fractional path owns one pair; paths I and J own two pairs each.
  always @* begin
    next_buffer_off = {PAIRS{1'b0}};
    next_buffer_off[7:0] = path_ah_pwr; // [RULE18]
    next_buffer_off[8] = ref_path_j[`BIT_PATH_I]; // [RULE19]
    next_buffer_off[9] = ref_path_j[`BIT_PATH_I]; // [RULE19]
    next_buffer_off[10] = ref_path_j[`BIT_PATH_J]; // [RULE19]
    next_buffer_off[11] = ref_path_j[`BIT_PATH_J]; // [RULE19]
  end

  // ----------------------------------------------------------------
  // Divider synchronisation
  // ----------------------------------------------------------------
  // Fine phase is sampled only at release, so rewriting it while running has no
  // effect until the next sync toggle.
  always @(posedge clock) begin
    if (!nrst) begin
      divider_reset <= 1'b0;
      divider_release <= 1'b0;
      skew_clear <= 1'b0;
      fine_phase_applied <= {`RST_FINE, `RST_FINE, `RST_FINE, `RST_FINE};
    end else begin
      if (sync_rise) begin
        divider_reset <= 1'b1; // [RULE1]
      end else if (sync_fall) begin
        divider_reset <= 1'b0; // [RULE2]
      end
      divider_release <= sync_fall; // [RULE2]
      skew_clear <= sync_fall; // [RULE2]
      if (sync_fall) begin
        // Order H,G,F,E,D,C,B,A from high nibble to low nibble.
        fine_phase_applied <= {fine_hf[`FLD_FINE_HI], fine_ge[`FLD_FINE_HI],
                               fine_hf[`FLD_FINE_LO], fine_ge[`FLD_FINE_LO],
                               fine_db[`FLD_FINE_HI], fine_ca[`FLD_FINE_HI],
                               fine_db[`FLD_FINE_LO], fine_ca[`FLD_FINE_LO]}; // [RULE23]
      end
    end
  end

  // ----------------------------------------------------------------
  // Source and power controls
  // ----------------------------------------------------------------
  // Powering a divider down leaves every select untouched; moving the pairs away
  // from it first is up to software.
  always @(posedge clock) begin
    if (!nrst) begin
      pair_source <= {4*PAIRS{1'b0}};
      divider_power_down <= {DIVIDERS{1'b0}};
      path_off <= {DIVIDERS{1'b0}};
      pair_buffer_off <= {PAIRS{1'b0}};
      ref_out_oe <= 1'b0;
      ref_out_off <= 1'b0;
      fractional_feedback_off <= 1'b0;
    end else begin
      pair_source <= next_source;
      // Divider I has no power-down bit of its own, so its position stays low.
      divider_power_down <= {div_j_pwr[`BIT_DIV_J], 1'b0, div_ah_pwr}; // [RULE11]
      path_off <= {ref_path_j[`BIT_PATH_J], ref_path_j[`BIT_PATH_I], path_ah_pwr}; // [RULE18]
      pair_buffer_off <= next_buffer_off;
      ref_out_oe <= byp_ref_pre[`BIT_REF_OE]; // [RULE16]
      ref_out_off <= ref_path_j[`BIT_REF_OFF];
      fractional_feedback_off <= fb_mode[`BIT_FEEDBACK_MODE_POWER];
    end
  end

  // ----------------------------------------------------------------
  // Loop settings
  // ----------------------------------------------------------------
  // The filter and lock settings are only stored and passed on; what they mean
  // in current, resistance or capacitance is decided inside the loop itself.
  always @(posedge clock) begin
    if (!nrst) begin
      prescale_mode <= `RST_PRESCALE;
      pump_current_code <= `RST_PUMP_CODE;
      loop_series_resistor <= `RST_SERIES_RES;
      loop_parallel_cap <= `RST_PAR_CAP;
      second_pole_select <= 1'b1;
      lock_count_accuracy <= 1'b1;
      lock_override_manual <= 1'b0;
      manual_oscillator_pick <= 1'b1;
      osc_manual_lock_code <= `RST_OSC_CODE;
    end else begin
      prescale_mode <= byp_ref_pre[`FLD_PRESCALE]; // [RULE17]
      pump_current_code <= pump_filter[`FLD_PUMP_CODE]; // [RULE21]
      loop_series_resistor <= pump_filter[`FLD_SERIES_RES]; // [RULE22]
      loop_parallel_cap <= pump_filter[`FLD_PAR_CAP]; // [RULE22]
      second_pole_select <= pump_filter[`BIT_SECOND_POLE]; // [RULE22]
      lock_count_accuracy <= lock_mode[`BIT_LOCK_COUNT]; // [RULE12]
      lock_override_manual <= lock_mode[`BIT_LOCK_OVERRIDE]; // [RULE13]
      manual_oscillator_pick <= vco1_lock[`BIT_OSC_PICK]; // [RULE14]
      // The code of the picked oscillator is presented to the lock logic. [RULE14]
      osc_manual_lock_code <= vco1_lock[`BIT_OSC_PICK] ? vco1_lock[`FLD_LOCK_CODE] :
                              vco2_lock[`FLD_LOCK_CODE];
    end
  end

endmodule

// file: core/clock_path_defs.vh
// Register offsets, field positions, reset values and source codes of the clock path control.
`ifndef CLOCK_PATH_DEFS_VH
`define CLOCK_PATH_DEFS_VH

`define ADDR_FINE_CA 16'h0087
`define ADDR_FINE_DB 16'h0088
`define ADDR_FINE_GE 16'h0089
`define ADDR_FINE_HF 16'h008A
`define ADDR_SYNC 16'h008D
`define ADDR_MUX_INT 16'h008E
`define ADDR_MUX_FRAC 16'h008F
`define ADDR_DIV_J_PWR 16'h0090
`define ADDR_DIV_AH_PWR 16'h0091
`define ADDR_PUMP_FILTER 16'h009A
`define ADDR_LOCK_MODE 16'h009B
`define ADDR_VCO1_LOCK 16'h009C
`define ADDR_VCO2_LOCK 16'h009D
`define ADDR_BYP_REF_PRE 16'h009E
`define ADDR_PLL_SPARE 16'h009F
`define ADDR_PATH_AH_PWR 16'h00A0
`define ADDR_REF_PATH_J 16'h00A1
`define ADDR_FB_MODE 16'h00A2

// Writable masks; reserved positions read back as zero.
`define MASK_SYNC 8'h01
`define MASK_MUX_INT 8'h03
`define MASK_MUX_FRAC 8'hFE
`define MASK_DIV_J_PWR 8'h01
`define MASK_LOCK_MODE 8'h03
`define MASK_VCO1_LOCK 8'h3F
`define MASK_VCO2_LOCK 8'h1F
`define MASK_BYP_REF_PRE 8'h17
`define MASK_REF_PATH_J 8'h13
`define MASK_FB_MODE 8'h02

// Field positions.
`define BIT_SYNC 0
`define BIT_MUX_8_9 0
`define BIT_MUX_10_11 1
`define BIT_LOCK_OVERRIDE 0
`define BIT_LOCK_COUNT 1
`define BIT_OSC_PICK 5
`define BIT_REF_OE 2
`define BIT_BYPASS 4
`define BIT_PATH_J 0
`define BIT_PATH_I 1
`define BIT_REF_OFF 4
`define BIT_FEEDBACK_MODE_POWER 1
`define BIT_DIV_J 0
`define BIT_SECOND_POLE 0
`define BIT_MUX_1 1
`define BIT_MUX_2 2
`define BIT_MUX_3 3
`define BIT_MUX_4 4
`define BIT_MUX_5 5
`define BIT_MUX_6 6
`define BIT_MUX_7 7
`define FLD_PUMP_CODE 7:5
`define FLD_SERIES_RES 4:3
`define FLD_PAR_CAP 2:1
`define FLD_PRESCALE 1:0
`define FLD_LOCK_CODE 4:0
`define FLD_FINE_HI 7:4
`define FLD_FINE_LO 3:0

// Reset values.
`define RST_ZERO 8'h00
`define RST_FINE 8'h44
`define RST_PUMP_FILTER 8'h8B
`define RST_LOCK_MODE 8'h02
`define RST_VCO1_LOCK 8'h2B
`define RST_VCO2_LOCK 8'h00
`define RST_BYP_REF_PRE 8'h03

// Reset values of the registered field copies.
`define RST_PUMP_CODE 3'h4
`define RST_SERIES_RES 2'h1
`define RST_PAR_CAP 2'h1
`define RST_OSC_CODE 5'h0B
`define RST_PRESCALE 2'h3

// Output pair source codes.
`define SRC_A 4'h0
`define SRC_B 4'h1
`define SRC_C 4'h2
`define SRC_D 4'h3
`define SRC_E 4'h4
`define SRC_F 4'h5
`define SRC_G 4'h6
`define SRC_H 4'h7
`define SRC_I 4'h8
`define SRC_J 4'h9
`define SRC_REF 4'hA

`endif
